//--- hdl/drc_pkg.sv
package drc_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] DRC_CTRL_OFFS  = 8'h00;
  localparam logic [7:0] DRC_LEVEL_OFFS = 8'h04;
  localparam logic [7:0] DRC_STAT_OFFS  = 8'h08;

  // Control register field positions
  localparam int DRC_EN_BIT  = 7;
  localparam int DRC_LPS_BIT = 6;
  localparam int DRC_OE_BIT  = 5;
  localparam int DRC_PSS_LSB = 2;
  localparam int DRC_NSS_BIT = 0;

  // Writable bit masks, everything else reads zero
  localparam logic [7:0] DRC_CTRL_MASK  = 8'hed;
  localparam logic [7:0] DRC_LEVEL_MASK = 8'h1f;

  // Reset values
  localparam logic [7:0] DRC_CTRL_RST  = 8'h00;
  localparam logic [7:0] DRC_LEVEL_RST = 8'h00;

  // Level code width and number of taps
  localparam int DRC_CODE_W = 5;
  localparam int DRC_LEVELS = 32;
  localparam logic [4:0] DRC_CODE_MAX = 5'h1f;
  localparam logic [4:0] DRC_CODE_MIN = 5'h00;

  // Positive source encodings
  typedef enum logic [1:0] {
    DRC_POS_SUPPLY = 2'b00,
    DRC_POS_PIN    = 2'b01,
    DRC_POS_FIXED  = 2'b10,
    DRC_POS_RSVD   = 2'b11
  } drc_pos_t;

  // Ladder mode
  typedef enum logic [1:0] {
    DRC_MODE_OFF   = 2'b00,
    DRC_MODE_LADDER = 2'b01,
    DRC_MODE_CLAMP_POS = 2'b10,
    DRC_MODE_CLAMP_NEG = 2'b11
  } drc_mode_t;

  // Analog switch controls toward the ladder macro
  typedef struct packed {
    logic        ladder_power;
    logic [31:0] tap_onehot;
    logic        pos_supply;
    logic        pos_pin;
    logic        pos_fixed;
    logic        neg_pin;
    logic        neg_ground;
    logic        pos_connect;
    logic        neg_connect;
    logic        short_pos;
    logic        short_neg;
  } drc_analog_t;

endpackage : drc_pkg

//--- hdl/drc_tap_decode.sv
module drc_tap_decode
  import drc_pkg::*;
#(
  parameter int LEVELS = DRC_LEVELS
) (
  // Tap selection
  input  wire logic [DRC_CODE_W-1:0] code,
  input  wire logic                  enable,
  // One-hot tap switches
  output logic      [LEVELS-1:0]     tap
);

  // One switch per ladder tap; all open while off to save current
  genvar i;
  generate
    for (i = 0; i < LEVELS; i++) begin : g_tap
      assign tap[i] = enable && (code == DRC_CODE_W'(i));
    end
  endgenerate

endmodule : drc_tap_decode

//--- hdl/drc_ladder_ctrl.sv
// Contract
// - The ladder is powered and operated only while the ladder enable bit is set.
// - There are 32 levels chosen by a 5-bit level code in the level select register.
// - While enabled the tap picks negative source plus difference times code over 32.
// - Disabled, low-power side set and code 11111 shorts the output to the positive source.
// - Disabled, low-power side clear and code 00000 shorts the output to the negative source.
// - Positive source is supply, reference pin or fixed reference; negative is ground or pin.
// - Positive select 00 supply, 01 pin, 10 fixed buffer, 11 reserved; negative 1 pin, 0 ground.
// - The reference goes to the output pin when the pin output enable bit is 1.
// - While routed, the pin's digital driver and input detector are disabled.
// - While routed, a read of the pin returns 0.
// - Low-power side set disconnects the negative source, clear disconnects the positive.
// - Reset disables the ladder, removes the pin output and clears the level code.
// - Wake from sleep leaves the control register unchanged.
module drc_ladder_ctrl
  import drc_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Sleep wake event from the core
  input  wire logic              wake_event,
  // Shared pin: port logic side
  input  wire logic              pin_in,
  input  wire logic              port_out,
  input  wire logic              port_oe,
  output logic                   pin_out,
  output logic                   pin_oe,
  output logic                   pin_in_enable,
  output logic                   port_read,
  // Analog ladder controls
  output drc_analog_t            analog,
  output logic                   reference_output_pin
);

  logic [7:0] ctrl_q;
  logic [7:0] level_q;
  logic       pin_s1_q;
  logic       pin_s2_q;
  logic [31:0] rdata_q;
  logic [31:0] taps;
  drc_mode_t  mode;
  drc_pos_t   pos_sel;
  logic       ladder_enable;
  logic       low_power_side_select;
  logic       pin_output_enable;
  logic       negative_source_select;
  logic [4:0] level_code;
  logic       wr_access;
  logic       rd_access;

  // Single-cycle access phase, no wait states
  assign pready    = 1'b1;
  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && !penable && !pwrite;

  // Address check shared by reads and writes
  function automatic logic known_addr(input logic [7:0] a);
    return (a == DRC_CTRL_OFFS) || (a == DRC_LEVEL_OFFS) || (a == DRC_STAT_OFFS);
  endfunction : known_addr

  assign pslverr = psel && penable && !known_addr(paddr);

  // Control register; wake_event deliberately has no effect on it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= DRC_CTRL_RST;
    end else if (wr_access && paddr == DRC_CTRL_OFFS && pstrb[0]) begin
      ctrl_q <= pwdata[7:0] & DRC_CTRL_MASK;
    end
  end

  // Level code register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= DRC_LEVEL_RST;
    end else if (wr_access && paddr == DRC_LEVEL_OFFS && pstrb[0]) begin
      level_q <= pwdata[7:0] & DRC_LEVEL_MASK;
    end
  end

  // Pin input synchroniser; stage one feeds stage two only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Field views
  assign ladder_enable          = ctrl_q[DRC_EN_BIT];
  assign low_power_side_select  = ctrl_q[DRC_LPS_BIT];
  assign pin_output_enable      = ctrl_q[DRC_OE_BIT];
  assign negative_source_select = ctrl_q[DRC_NSS_BIT];
  assign pos_sel                = drc_pos_t'(ctrl_q[DRC_PSS_LSB+:2]);
  assign level_code             = level_q[DRC_CODE_W-1:0];

  // Mode: clamps need both the low-power side and the matching end code
  always_comb begin
    if (ladder_enable) begin
      mode = DRC_MODE_LADDER;
    end else if (low_power_side_select && level_code == DRC_CODE_MAX) begin
      mode = DRC_MODE_CLAMP_POS;
    end else if (!low_power_side_select && level_code == DRC_CODE_MIN) begin
      mode = DRC_MODE_CLAMP_NEG;
    end else begin
      mode = DRC_MODE_OFF;
    end
  end

  // Tap switches: tap k gives neg + (pos - neg) * k / 32
  drc_tap_decode #(
    .LEVELS (DRC_LEVELS)
  ) u_taps (
    .code   (level_code),
    .enable (mode == DRC_MODE_LADDER),
    .tap    (taps)
  );

  // Source selection and connection switches
  always_comb begin
    analog              = '0;
    analog.ladder_power = (mode == DRC_MODE_LADDER);
    analog.tap_onehot   = taps;
    // Reserved positive code leaves every positive switch open
    unique case (pos_sel)
      DRC_POS_SUPPLY: begin
        analog.pos_supply = 1'b1;
      end
      DRC_POS_PIN: begin
        analog.pos_pin = 1'b1;
      end
      DRC_POS_FIXED: begin
        analog.pos_fixed = 1'b1;
      end
      DRC_POS_RSVD: begin
        analog.pos_supply = 1'b0;
      end
    endcase
    analog.neg_pin    = negative_source_select;
    analog.neg_ground = !negative_source_select;
    if (ladder_enable) begin
      analog.pos_connect = 1'b1;
      analog.neg_connect = 1'b1;
    end else begin
      // Low power: cut one end so no current flows through the ladder
      analog.pos_connect = low_power_side_select;
      analog.neg_connect = !low_power_side_select;
    end
    analog.short_pos = (mode == DRC_MODE_CLAMP_POS);
    analog.short_neg = (mode == DRC_MODE_CLAMP_NEG);
  end

  // Pin override: analog path wins over the digital port
  assign reference_output_pin = pin_output_enable;
  assign pin_oe        = port_oe && !pin_output_enable;
  assign pin_out       = pin_output_enable ? 1'b0 : port_out;
  assign pin_in_enable = !pin_output_enable;
  assign port_read     = pin_s2_q && !pin_output_enable;

  // Read data registered at setup, held through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_access) begin
      unique case (paddr)
        DRC_CTRL_OFFS:  rdata_q <= {24'h00_0000, ctrl_q};
        DRC_LEVEL_OFFS: rdata_q <= {24'h00_0000, level_q};
        DRC_STAT_OFFS:  rdata_q <= {28'h000_0000, mode, analog.ladder_power, port_read};
        default:        rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = rdata_q;

  // Checks
  a_ladder_power_en: assert property (@(posedge pclk) disable iff (!presetn)
    analog.ladder_power == ladder_enable) else $error("ladder power mismatch");
  a_tap_onehot_sel: assert property (@(posedge pclk) disable iff (!presetn)
    ladder_enable |-> analog.tap_onehot == (32'h1 << level_code))
    else $error("wrong tap selected");
  a_level_write_seen: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && paddr == DRC_LEVEL_OFFS && pstrb[0]) |=> level_q == ($past(pwdata[7:0]) & 8'h1f))
    else $error("level write lost");
  a_clamp_pos_short: assert property (@(posedge pclk) disable iff (!presetn)
    analog.short_pos == (!ladder_enable && low_power_side_select && level_code == 5'h1f))
    else $error("positive clamp wrong");
  a_clamp_neg_short: assert property (@(posedge pclk) disable iff (!presetn)
    analog.short_neg == (!ladder_enable && !low_power_side_select && level_code == 5'h00))
    else $error("negative clamp wrong");
  a_pos_src_decode: assert property (@(posedge pclk) disable iff (!presetn)
    (pos_sel == DRC_POS_FIXED) |-> (analog.pos_fixed && !analog.pos_pin && !analog.pos_supply))
    else $error("positive source decode");
  a_neg_src_decode: assert property (@(posedge pclk) disable iff (!presetn)
    analog.neg_pin != analog.neg_ground) else $error("negative source decode");
  a_pin_override: assert property (@(posedge pclk) disable iff (!presetn)
    reference_output_pin |-> (!pin_oe && !pin_in_enable && !port_read))
    else $error("pin not overridden");
  a_low_power_cut: assert property (@(posedge pclk) disable iff (!presetn)
    !ladder_enable |-> (analog.neg_connect == !low_power_side_select))
    else $error("low power side wrong");
  a_ctrl_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q & 8'h12) == 8'h00 && level_q[7:5] == 3'h0) else $error("reserved bit set");
  a_wake_no_effect: assert property (@(posedge pclk) disable iff (!presetn)
    (wake_event && !wr_access) |=> $stable(ctrl_q)) else $error("wake changed control");


  // Reset values, checked while reset is held
  a_reset_clears_regs: assert property (@(posedge pclk)
    !presetn
    |-> (ctrl_q == 8'h00 && level_q == 8'h00 && !reference_output_pin))
    else $error("reset left state");

  // Register writes land with only the implemented bits
  a_ctrl_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && paddr == DRC_CTRL_OFFS && pstrb[0])
    |=> ctrl_q == ($past(pwdata[7:0]) & 8'hed))
    else $error("control write lost");
  a_pin_route_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && paddr == DRC_CTRL_OFFS && pstrb[0])
    |=> reference_output_pin == $past(pwdata[5]))
    else $error("pin route not taken");
  a_wake_level_stable: assert property (@(posedge pclk) disable iff (!presetn)
    (wake_event && !wr_access)
    |=> $stable(level_q))
    else $error("wake changed level");

  // Read data captured at the setup edge
  a_read_ctrl_data: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_access && paddr == DRC_CTRL_OFFS)
    |=> prdata == {24'h00_0000, $past(ctrl_q)})
    else $error("control read wrong");
  a_read_level_data: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_access && paddr == DRC_LEVEL_OFFS)
    |=> prdata == {24'h00_0000, $past(level_q)})
    else $error("level read wrong");
  a_read_stat_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_access && paddr == DRC_STAT_OFFS)
    |=> prdata[3:2] == $past(mode))
    else $error("status read wrong");
  a_known_no_error: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && known_addr(paddr))
    |-> !pslverr && pready)
    else $error("error on mapped register");

  // Ladder ends and taps
  a_ladder_both_ends: assert property (@(posedge pclk) disable iff (!presetn)
    ladder_enable
    |-> (analog.pos_connect && analog.neg_connect))
    else $error("ladder end open");
  a_taps_off_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    !ladder_enable
    |-> analog.tap_onehot == 32'h0000_0000)
    else $error("tap closed while off");
  a_clamp_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
    !(analog.short_pos && analog.short_neg)
    ) else $error("both clamps closed");
  a_low_power_pos_cut: assert property (@(posedge pclk) disable iff (!presetn)
    !ladder_enable
    |-> (analog.pos_connect == low_power_side_select))
    else $error("positive side wrong");

  // Source decode, one switch per code, none for the reserved code
  a_pos_supply_decode: assert property (@(posedge pclk) disable iff (!presetn)
    (pos_sel == DRC_POS_SUPPLY)
    |-> (analog.pos_supply && !analog.pos_pin && !analog.pos_fixed))
    else $error("supply decode");
  a_pos_pin_decode: assert property (@(posedge pclk) disable iff (!presetn)
    (pos_sel == DRC_POS_PIN)
    |-> (analog.pos_pin && !analog.pos_supply && !analog.pos_fixed))
    else $error("pin source decode");
  a_pos_rsvd_open: assert property (@(posedge pclk) disable iff (!presetn)
    (pos_sel == DRC_POS_RSVD)
    |-> !(analog.pos_pin || analog.pos_supply || analog.pos_fixed))
    else $error("reserved source closed");
  a_neg_ground_decode: assert property (@(posedge pclk) disable iff (!presetn)
    !negative_source_select
    |-> (analog.neg_ground && !analog.neg_pin))
    else $error("ground decode");

  // Pin ownership
  a_pin_drive_free: assert property (@(posedge pclk) disable iff (!presetn)
    !reference_output_pin
    |-> (pin_oe == port_oe && pin_out == port_out && pin_in_enable))
    else $error("port lost the pin");
  a_pin_out_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    reference_output_pin
    |-> !pin_out)
    else $error("digital drive while routed");
  a_port_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pin_output_enable
    |-> !port_read)
    else $error("routed pin reads one");
  a_pin_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |-> pin_s2_q == $past(pin_s1_q))
    else $error("sync stage skipped");

  c_ladder_on:  cover property (@(posedge pclk) disable iff (!presetn) analog.ladder_power);
  c_clamp_pos:  cover property (@(posedge pclk) disable iff (!presetn) analog.short_pos);
  c_clamp_neg:  cover property (@(posedge pclk) disable iff (!presetn) analog.short_neg);
  c_pin_routed: cover property (@(posedge pclk) disable iff (!presetn) reference_output_pin);
  c_pos_fixed:  cover property (@(posedge pclk) disable iff (!presetn) analog.pos_fixed);

endmodule : drc_ladder_ctrl

//--- tb/drc_ladder_ctrl_tb.sv
module drc_ladder_ctrl_tb;
  import drc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk, presetn, psel, penable, pwrite, wake_event;
  logic        pin_in, port_out, port_oe, pready, pslverr;
  logic        pin_out, pin_oe, pin_in_enable, port_read, ref_pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  drc_analog_t analog;
  int          fail_count, checks, cycles;
  logic [2:0]  pos_exp [4] = '{3'b100, 3'b010, 3'b001, 3'b000};

  drc_ladder_ctrl u_drc_ladder_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_event(wake_event),
    .pin_in(pin_in), .port_out(port_out), .port_oe(port_oe), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_in_enable(pin_in_enable), .port_read(port_read),
    .analog(analog), .reference_output_pin(ref_pin));

  // Clock and hang guard; the run needs well under a thousand cycles
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One APB transfer; waits for pready, then settles to the falling edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hf);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    chk(pslverr, (a > DRC_STAT_OFFS), "slverr");
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask : apb

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  initial begin
    {pclk, presetn, psel, penable, pwrite, wake_event} = '0;
    {pin_in, port_out, port_oe, paddr, pwdata, pstrb} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    // Reset state: ladder off, pin free, negative clamp
    chk({analog.ladder_power, ref_pin, analog.short_neg}, 3'b001, "rst out");
    apb(0, DRC_CTRL_OFFS, 0);
    chk(rd, 0, "rst ctrl");
    // Unimplemented bits dropped, refused strobe and unmapped address
    apb(1, DRC_CTRL_OFFS, 32'hff);
    apb(0, DRC_CTRL_OFFS, 0);
    chk(rd, 32'hed, "ctrl mask");
    apb(1, DRC_LEVEL_OFFS, 32'hff);
    apb(0, DRC_LEVEL_OFFS, 0);
    chk(rd, 32'h1f, "level mask");
    apb(1, DRC_LEVEL_OFFS, 32'h03, 4'h0);
    apb(1, 8'h0c, 32'h03);
    apb(0, 8'h0c, 0);
    chk(rd, 0, "unmapped");
    apb(0, DRC_LEVEL_OFFS, 0);
    chk(rd, 32'h1f, "strobe off");
    // Every code picks its own tap while enabled
    apb(1, DRC_CTRL_OFFS, 32'h80);
    chk({analog.ladder_power, analog.pos_connect, analog.neg_connect}, 3'b111, "on");
    for (int i = 0; i < DRC_LEVELS; i++) begin
      apb(1, DRC_LEVEL_OFFS, 32'(i));
      chk(analog.tap_onehot, 32'h1 << i, "tap");
    end
    // Source selects, the reserved code opens all positive switches
    for (int s = 0; s < 4; s++) begin
      apb(1, DRC_CTRL_OFFS, 32'h80 | 32'(s << 2) | 32'(s & 1));
      chk({analog.pos_supply, analog.pos_pin, analog.pos_fixed}, pos_exp[s], "pos");
      chk({analog.neg_pin, analog.neg_ground}, (s & 1) ? 2'b10 : 2'b01, "neg");
    end
    // Clamp to positive source: negative side cut
    apb(1, DRC_CTRL_OFFS, 32'h40);
    chk({analog.ladder_power, analog.tap_onehot}, 0, "off");
    chk({analog.short_pos, analog.pos_connect, analog.neg_connect}, 3'b110, "clamp+");
    apb(0, DRC_STAT_OFFS, 0);
    chk(rd & 32'he, 32'h8, "stat clamp+");
    // Clamp to negative source: positive side cut
    apb(1, DRC_LEVEL_OFFS, 0);
    apb(1, DRC_CTRL_OFFS, 32'h00);
    chk({analog.short_neg, analog.pos_connect, analog.neg_connect}, 3'b101, "clamp-");
    // Pin owned by the port while not routed
    port_oe  <= 1'b1;
    port_out <= 1'b1;
    pin_in   <= 1'b1;
    repeat (3) @(negedge pclk);
    chk({pin_oe, pin_out, pin_in_enable, port_read, ref_pin}, 5'b11110, "port");
    // Routed: digital driver, detector and read all off
    apb(1, DRC_CTRL_OFFS, 32'ha5);
    chk({ref_pin, pin_oe, pin_in_enable, port_read}, 4'b1000, "routed");
    // Wake event leaves control alone
    @(posedge pclk) wake_event <= 1'b1;
    @(posedge pclk) wake_event <= 1'b0;
    apb(0, DRC_CTRL_OFFS, 0);
    chk(rd, 32'ha5, "wake");
    // Reset in mid-run clears everything again
    apb(1, DRC_LEVEL_OFFS, 32'h11);
    @(posedge pclk) presetn <= 1'b0;
    @(posedge pclk) presetn <= 1'b1;
    @(negedge pclk);
    chk({ref_pin, analog.ladder_power}, 0, "rst2 out");
    apb(0, DRC_LEVEL_OFFS, 0);
    chk(rd, 0, "rst2 level");
    apb(0, DRC_CTRL_OFFS, 0);
    chk(rd, 0, "rst2 ctrl");
    finish_test();
  end

endmodule : drc_ladder_ctrl_tb
